/* File: hdl/apcr_regs.sv */
// How it works
// - four serial input pad registers at consecutive indices from f790
// - four serial output pad registers at consecutive indices from f794
// - serial input pad registers reset to 0018, pull-down enabled
// - serial output pad registers reset to 0008, pull-down disabled
// - transmitter pad register at f798 resets to 0008, optional by variant
// - control clock pad register at f799, bit 4 enables a pull-up
// - control data-out pad register at f79a resets to 0008
// - bits 1:0 drive, bits 3:2 slew, both read-write, 00 weakest
// - transmitter pad bit 4 is a pull-down enable, 1 enables
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module apcr_regs #(
    parameter int unsigned HAS_AUDIO_TX = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial input data pads
    output logic [3:0] input_pad_pulldown_en,
    output logic [7:0] input_pad_slew_sel,
    output logic [7:0] input_pad_drive_sel,
    // serial output data pads
    output logic [3:0] output_pad_pulldown_en,
    output logic [7:0] output_pad_slew_sel,
    output logic [7:0] output_pad_drive_sel,
    // digital audio transmitter pad
    output logic tx_pad_pulldown_en,
    output logic [1:0] tx_pad_slew_sel,
    output logic [1:0] tx_pad_drive_sel,
    // control clock pad
    output logic ctrl_clock_pullup_en,
    output logic [1:0] ctrl_clock_slew_sel,
    output logic [1:0] ctrl_clock_drive_sel,
    // control data-out pad
    output logic ctrl_data_pullup_en,
    output logic [1:0] ctrl_data_slew_sel,
    output logic [1:0] ctrl_data_drive_sel
);

    // variant flag only selects with or without the transmitter pad
    if (HAS_AUDIO_TX > 1) begin : g_bad_variant
        $error("HAS_AUDIO_TX must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////

    // maps a byte address to a register slot; NUM_REGS means unmapped
    function automatic logic [3:0] slot_of(input logic [31:0] addr);
        logic [31:0] base;
        logic [31:0] off;
        base = {14'h0000, apcr_pkg::SERIAL_IN0_IDX, 2'b00};
        off = addr - base;
        slot_of = 4'(apcr_pkg::NUM_REGS);
        if (addr[1:0] == 2'b00 && addr >= base && off[31:2] < 30'(apcr_pkg::NUM_REGS)) begin
            slot_of = off[5:2];
        end
        if (HAS_AUDIO_TX == 0 && off[31:2] == 30'(apcr_pkg::AUDIO_TX_IDX - apcr_pkg::SERIAL_IN0_IDX)
            && addr[1:0] == 2'b00) begin
            slot_of = 4'(apcr_pkg::NUM_REGS);
        end
    endfunction : slot_of

    logic [3:0] slot;
    logic mapped;
    logic access;
    logic [15:0] regs [apcr_pkg::NUM_REGS];
    logic [15:0] wr_data;

    assign slot = slot_of(paddr);
    assign mapped = slot < 4'(apcr_pkg::NUM_REGS);
    assign access = psel && penable;
    // byte lanes: only the two low lanes hold register bits
    assign wr_data = {pstrb[1] ? pwdata[15:8] : regs[slot < 4'(apcr_pkg::NUM_REGS) ? slot : 4'h0][15:8],
                      pstrb[0] ? pwdata[7:0] : regs[slot < 4'(apcr_pkg::NUM_REGS) ? slot : 4'h0][7:0]};

    ////////////////////////////////////////////////////////////////////////

    genvar g;
    generate
        for (g = 0; g < apcr_pkg::NUM_REGS; g++) begin : g_reg
            localparam logic [15:0] RV = (g < 4) ? apcr_pkg::SERIAL_IN_RESET :
                                         (g < 8) ? apcr_pkg::SERIAL_OUT_RESET :
                                         (g == 8) ? apcr_pkg::AUDIO_TX_RESET :
                                         (g == 9) ? apcr_pkg::CTRL_CLOCK_RESET :
                                         apcr_pkg::CTRL_DATA_OUT_RESET;
            apcr_pad_reg #(
                .RESET_VALUE(RV)
            ) u_reg (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(access && pwrite && mapped && slot == 4'(g) && !pready),
                .wr_data(wr_data),
                .value_q(regs[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    // one wait state: answer in the cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access && !pready && !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (access && !pready && !pwrite && mapped) begin
            prdata <= {16'h0000, regs[slot]};
        end else begin
            prdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // outputs registered again so every port comes from a flop
    generate
        for (g = 0; g < apcr_pkg::NUM_PINS; g++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    input_pad_pulldown_en[g] <= apcr_pkg::SERIAL_IN_RESET[apcr_pkg::PULL_BIT];
                    input_pad_slew_sel[2*g +: 2] <= apcr_pkg::SERIAL_IN_RESET[apcr_pkg::SLEW_LSB +: 2];
                    input_pad_drive_sel[2*g +: 2] <= apcr_pkg::SERIAL_IN_RESET[apcr_pkg::DRIVE_LSB +: 2];
                    output_pad_pulldown_en[g] <= apcr_pkg::SERIAL_OUT_RESET[apcr_pkg::PULL_BIT];
                    output_pad_slew_sel[2*g +: 2] <= apcr_pkg::SERIAL_OUT_RESET[apcr_pkg::SLEW_LSB +: 2];
                    output_pad_drive_sel[2*g +: 2] <= apcr_pkg::SERIAL_OUT_RESET[apcr_pkg::DRIVE_LSB +: 2];
                end else begin
                    input_pad_pulldown_en[g] <= regs[g][apcr_pkg::PULL_BIT];
                    input_pad_slew_sel[2*g +: 2] <= regs[g][apcr_pkg::SLEW_LSB +: 2];
                    input_pad_drive_sel[2*g +: 2] <= regs[g][apcr_pkg::DRIVE_LSB +: 2];
                    output_pad_pulldown_en[g] <= regs[g+4][apcr_pkg::PULL_BIT];
                    output_pad_slew_sel[2*g +: 2] <= regs[g+4][apcr_pkg::SLEW_LSB +: 2];
                    output_pad_drive_sel[2*g +: 2] <= regs[g+4][apcr_pkg::DRIVE_LSB +: 2];
                end
            end
        end
    endgenerate

    // transmitter pad, held at reset value when absent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pad_pulldown_en <= apcr_pkg::AUDIO_TX_RESET[apcr_pkg::PULL_BIT];
            tx_pad_slew_sel <= apcr_pkg::AUDIO_TX_RESET[apcr_pkg::SLEW_LSB +: 2];
            tx_pad_drive_sel <= apcr_pkg::AUDIO_TX_RESET[apcr_pkg::DRIVE_LSB +: 2];
        end else begin
            tx_pad_pulldown_en <= regs[8][apcr_pkg::PULL_BIT];
            tx_pad_slew_sel <= regs[8][apcr_pkg::SLEW_LSB +: 2];
            tx_pad_drive_sel <= regs[8][apcr_pkg::DRIVE_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_clock_pullup_en <= apcr_pkg::CTRL_CLOCK_RESET[apcr_pkg::PULL_BIT];
            ctrl_clock_slew_sel <= apcr_pkg::CTRL_CLOCK_RESET[apcr_pkg::SLEW_LSB +: 2];
            ctrl_clock_drive_sel <= apcr_pkg::CTRL_CLOCK_RESET[apcr_pkg::DRIVE_LSB +: 2];
            ctrl_data_pullup_en <= apcr_pkg::CTRL_DATA_OUT_RESET[apcr_pkg::PULL_BIT];
            ctrl_data_slew_sel <= apcr_pkg::CTRL_DATA_OUT_RESET[apcr_pkg::SLEW_LSB +: 2];
            ctrl_data_drive_sel <= apcr_pkg::CTRL_DATA_OUT_RESET[apcr_pkg::DRIVE_LSB +: 2];
        end else begin
            ctrl_clock_pullup_en <= regs[9][apcr_pkg::PULL_BIT];
            ctrl_clock_slew_sel <= regs[9][apcr_pkg::SLEW_LSB +: 2];
            ctrl_clock_drive_sel <= regs[9][apcr_pkg::DRIVE_LSB +: 2];
            ctrl_data_pullup_en <= regs[10][apcr_pkg::PULL_BIT];
            ctrl_data_slew_sel <= regs[10][apcr_pkg::SLEW_LSB +: 2];
            ctrl_data_drive_sel <= regs[10][apcr_pkg::DRIVE_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////

    chk_in_pad_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> input_pad_drive_sel[1:0] == $past(regs[0][1:0]) && input_pad_pulldown_en[3] == $past(regs[3][4]))
        else $error("serial input pad outputs do not follow registers");

    chk_out_pad_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> output_pad_slew_sel[7:6] == $past(regs[7][3:2]) && output_pad_pulldown_en[0] == $past(regs[4][4]))
        else $error("serial output pad outputs do not follow registers");

    chk_in_reset_val: assert property (@(posedge pclk)
        $rose(presetn) |-> regs[0] == 16'h0018 && regs[3] == 16'h0018)
        else $error("serial input register reset value wrong");

    chk_out_reset_val: assert property (@(posedge pclk)
        $rose(presetn) |-> regs[4] == 16'h0008 && regs[7] == 16'h0008)
        else $error("serial output register reset value wrong");

    chk_tx_reset_val: assert property (@(posedge pclk)
        $rose(presetn) |-> regs[8] == 16'h0008 && !tx_pad_pulldown_en)
        else $error("transmitter register reset value wrong");

    // clock pad pull-up tracks bit 4
    chk_clk_pullup_bit: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(regs[9][4]) |=> ctrl_clock_pullup_en == regs[9][4])
        else $error("control clock pull-up does not track bit 4");

    chk_data_pad_write: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !pready && mapped && slot == 4'd10 && pstrb[0]
        |=> ##1 ctrl_data_drive_sel == $past(pwdata[1:0], 2))
        else $error("control data pad write not applied");

    chk_read_fields: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && !pready && mapped |=> pready && prdata[15:0] == $past(regs[slot]) && prdata[31:16] == 16'h0000)
        else $error("read data mismatch");

    chk_tx_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> tx_pad_pulldown_en == $past(regs[8][4]))
        else $error("transmitter pull-down does not follow bit 4");

    // reserved bits stay zero without writes
    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        regs[5][15:5] == 11'h000 && !(access && pwrite && slot == 4'd5) |=> regs[5][15:5] == 11'h000)
        else $error("reserved bits changed without a write");

    ////////////////////////////////////////////////////////////////////////

    chk_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready |=> pready)
        else $error("no answer one cycle after the access phase began");

    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");

    chk_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !access |=> !pready)
        else $error("ready without an access phase");

    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && !mapped |=> pready && pslverr)
        else $error("unmapped access did not answer an error");

    chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready && mapped |=> !pslverr)
        else $error("mapped access answered an error");

    chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without ready");

    chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h00000000)
        else $error("read data not zero outside an answer");

    chk_rdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");

    chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !pready && mapped && pstrb[1:0] == 2'b11
        |=> regs[$past(slot)] == $past(pwdata[15:0]))
        else $error("full word write not stored");

    // low lane write keeps high byte
    chk_low_lane_only: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !pready && mapped && pstrb[1:0] == 2'b01
        |=> regs[$past(slot)][15:8] == $past(regs[slot][15:8]))
        else $error("high byte changed by a low lane write");

    chk_no_write_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !pready && !mapped |=> regs[0] == $past(regs[0]) && regs[10] == $past(regs[10]))
        else $error("refused write changed a register");

    chk_regs_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && !pready) |=> regs[9] == $past(regs[9]))
        else $error("control clock register changed without a write");

    chk_in_slew_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> input_pad_slew_sel[5:4] == $past(regs[2][3:2]))
        else $error("serial input slew does not follow register");

    // input drive and slew of end pins
    chk_in_end_pins: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> input_pad_drive_sel[7:6] == $past(regs[3][1:0]) && input_pad_slew_sel[1:0] == $past(regs[0][3:2]))
        else $error("serial input end pins do not follow registers");

    chk_out_drive_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> output_pad_drive_sel[3:2] == $past(regs[5][1:0]) && output_pad_pulldown_en[1] == $past(regs[5][4]))
        else $error("serial output drive does not follow register");

    chk_ctrl_data_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ctrl_data_pullup_en == $past(regs[10][4]) && ctrl_data_slew_sel == $past(regs[10][3:2]))
        else $error("control data pad does not follow register");

    chk_clk_reset_val: assert property (@(posedge pclk)
        $rose(presetn) |-> regs[9] == 16'h0008 && regs[10] == 16'h0008 && !ctrl_clock_pullup_en)
        else $error("control pad register reset value wrong");

    chk_pull_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> input_pad_pulldown_en == 4'hf && output_pad_pulldown_en == 4'h0)
        else $error("pull enables wrong after reset");

    chk_tx_fields: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> tx_pad_slew_sel == $past(regs[8][3:2]) && tx_pad_drive_sel == $past(regs[8][1:0]))
        else $error("transmitter fields do not follow register");

    chk_tx_absent: assert property (@(posedge pclk) disable iff (!presetn)
        HAS_AUDIO_TX == 0 |-> regs[8] == apcr_pkg::AUDIO_TX_RESET)
        else $error("absent transmitter register was written");

endmodule : apcr_regs
`default_nettype wire

/* File: hdl/apcr_pkg.sv */
`default_nettype none
package apcr_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] SERIAL_IN0_IDX = 16'hf790;
    localparam logic [15:0] SERIAL_IN1_IDX = 16'hf791;
    localparam logic [15:0] SERIAL_IN2_IDX = 16'hf792;
    localparam logic [15:0] SERIAL_IN3_IDX = 16'hf793;
    localparam logic [15:0] SERIAL_OUT0_IDX = 16'hf794;
    localparam logic [15:0] SERIAL_OUT1_IDX = 16'hf795;
    localparam logic [15:0] SERIAL_OUT2_IDX = 16'hf796;
    localparam logic [15:0] SERIAL_OUT3_IDX = 16'hf797;
    localparam logic [15:0] AUDIO_TX_IDX = 16'hf798;
    localparam logic [15:0] CTRL_CLOCK_IDX = 16'hf799;
    localparam logic [15:0] CTRL_DATA_OUT_IDX = 16'hf79a;

    localparam int unsigned NUM_REGS = 11;
    localparam int unsigned NUM_PINS = 4;

    // field positions
    localparam int unsigned DRIVE_LSB = 0;
    localparam int unsigned SLEW_LSB = 2;
    localparam int unsigned PULL_BIT = 4;

    // values after reset
    localparam logic [15:0] SERIAL_IN_RESET = 16'h0018;
    localparam logic [15:0] SERIAL_OUT_RESET = 16'h0008;
    localparam logic [15:0] AUDIO_TX_RESET = 16'h0008;
    localparam logic [15:0] CTRL_CLOCK_RESET = 16'h0008;
    localparam logic [15:0] CTRL_DATA_OUT_RESET = 16'h0008;

    typedef enum logic [1:0] {
        APCR_LVL_MIN = 2'b00,
        APCR_LVL_LOW = 2'b01,
        APCR_LVL_HIGH = 2'b10,
        APCR_LVL_MAX = 2'b11
    } apcr_level_t;

endpackage : apcr_pkg
`default_nettype wire

/* File: hdl/apcr_pad_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module apcr_pad_reg #(
    parameter logic [15:0] RESET_VALUE = 16'h0008
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    // stored value
    output logic [15:0] value_q
);

    // reserved bits stored too, so software reads back what it wrote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RESET_VALUE;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end

endmodule : apcr_pad_reg
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic rd; logic err; logic [31:0] d;} apcr_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb, ipull, opull;
    logic [7:0] islew, idrv, oslew, odrv;
    logic tpull, cpull, dpull;
    logic [1:0] tslew, tdrv, cslew, cdrv, dslew, ddrv;
    apcr_note_t exp_q[$];
    apcr_note_t got_n;
    logic [15:0] model [0:10];
    logic [31:0] lfsr_q, d;
    logic [3:0] s;
    int error_cnt, samples_checked, cycles;

    apcr_regs #(.HAS_AUDIO_TX(1)) i_apcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .input_pad_pulldown_en(ipull), .input_pad_slew_sel(islew),
        .input_pad_drive_sel(idrv), .output_pad_pulldown_en(opull), .output_pad_slew_sel(oslew),
        .output_pad_drive_sel(odrv), .tx_pad_pulldown_en(tpull), .tx_pad_slew_sel(tslew),
        .tx_pad_drive_sel(tdrv), .ctrl_clock_pullup_en(cpull), .ctrl_clock_slew_sel(cslew),
        .ctrl_clock_drive_sel(cdrv), .ctrl_data_pullup_en(dpull), .ctrl_data_slew_sel(dslew),
        .ctrl_data_drive_sel(ddrv));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    // printed offsets are word indices, so the byte address is four times
    function automatic logic [31:0] byte_addr(input int i);
        return {14'h0, 16'hf790 + 16'(i), 2'b00};
    endfunction : byte_addr

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic complete_run;
        $display("counts: %0d checked, %0d wrong", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // note the expectation first, then run setup and access phases
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] st,
                       input logic [31:0] exp_d, input logic exp_e);
        apcr_note_t n;
        n.rd = !wr;
        n.err = exp_e;
        n.d = exp_d;
        exp_q.push_back(n);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_pads;
        logic [19:0] ein, eout;
        for (int i = 0; i < 4; i++) begin
            ein[16+i] = model[i][4];
            ein[8+2*i+:2] = model[i][3:2];
            ein[2*i+:2] = model[i][1:0];
            eout[16+i] = model[i+4][4];
            eout[8+2*i+:2] = model[i+4][3:2];
            eout[2*i+:2] = model[i+4][1:0];
        end
        cmp({12'h0, ipull, islew, idrv}, {12'h0, ein}, "input pads");
        cmp({12'h0, opull, oslew, odrv}, {12'h0, eout}, "output pads");
        cmp({27'h0, tpull, tslew, tdrv}, {27'h0, model[8][4:0]}, "tx pad");
        cmp({27'h0, cpull, cslew, cdrv}, {27'h0, model[9][4:0]}, "clock pad");
        cmp({27'h0, dpull, dslew, ddrv}, {27'h0, model[10][4:0]}, "data pad");
    endtask : check_pads

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("wrong value at %0t: run hung", $time);
            complete_run();
        end
    end

    // one note per answer, taken at the edge where pready is sampled
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp(32'h1, 32'h0, "unexpected answer");
            end else begin
                got_n = exp_q.pop_front();
                cmp({31'h0, pslverr}, {31'h0, got_n.err}, "error flag");
                if (got_n.rd) cmp(prdata, got_n.d, "read data");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        lfsr_q = 32'he4a7949a;
        for (int i = 0; i < 11; i++) model[i] = (i < 4) ? 16'h0018 : 16'h0008;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_pads();
        for (int i = 0; i < 11; i++) apb(1'b0, byte_addr(i), 32'h0, 4'h0, {16'h0, model[i]}, 1'b0);
        $display("test reset values done");
        // passes 0..3 walk every drive and slew code, the rest are random with random strobes
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 11; i++) begin
                lfsr_q = lfsr_next(lfsr_q);
                d = (k < 4) ? {27'h0, k[0], k[1:0], k[1:0]} : lfsr_q;
                s = (k < 4) ? 4'hf : lfsr_q[23:20];
                if (s[0]) model[i][7:0] = d[7:0];
                if (s[1]) model[i][15:8] = d[15:8];
                apb(1'b1, byte_addr(i), d, s, 32'h0, 1'b0);
                apb(1'b0, byte_addr(i), 32'h0, 4'h0, {16'h0, model[i]}, 1'b0);
            end
            repeat (2) @(posedge pclk);
            check_pads();
        end
        $display("test field writes done");
        // refused places must not disturb any register
        apb(1'b1, byte_addr(11), 32'hffff, 4'hf, 32'h0, 1'b1);
        apb(1'b0, byte_addr(11), 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b1, byte_addr(-1), 32'hffff, 4'hf, 32'h0, 1'b1);
        apb(1'b1, byte_addr(0) | 32'h1, 32'hffff, 4'hf, 32'h0, 1'b1);
        for (int i = 0; i < 11; i++) apb(1'b0, byte_addr(i), 32'h0, 4'h0, {16'h0, model[i]}, 1'b0);
        repeat (3) @(posedge pclk);
        check_pads();
        cmp(32'(exp_q.size()), 32'h0, "missing answers");
        $display("test refused access done");
        // second reset in mid-run must bring every register back
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) model[i] = (i < 4) ? 16'h0018 : 16'h0008;
        @(posedge pclk);
        check_pads();
        for (int i = 0; i < 11; i++) apb(1'b0, byte_addr(i), 32'h0, 4'h0, {16'h0, model[i]}, 1'b0);
        repeat (3) @(posedge pclk);
        $display("test second reset done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
